// [design/sop_pkg.sv]
package sop_pkg;
	// command bytes
	localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_PROTECT_CONFIG_READ = 8'h89;
	localparam logic [7:0] CMD_READOUT_LOCK = 8'h85;

	// status register field positions
	localparam int ST_UNLOCK_BIT = 5;
	localparam int ST_BUSY_BIT = 4;
	localparam int ST_PAGE_BIT = 3;
	localparam int ST_LOCK_BIT = 2;

	// memory geometry
	localparam int MEM_DEPTH = 17920;
	localparam int MEM_AW = 15;
	localparam int STAGE_DEPTH = 256;
	localparam int STAGE_AW = 8;
	localparam int FIFO_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam logic [14:0] PRIMARY_BYTES = 15'h4400;
	localparam logic [15:0] PRIMARY_LAST_ADDR = 16'h43FF;
	localparam logic [15:0] CONFIG_LAST_ADDR = 16'h01FF;
	localparam logic [15:0] LOCK_BYTE_ADDR = 16'h0023;

	// byte values
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] LOCK_MARK = 8'h00;
	localparam logic [7:0] PROTECT_CONFIG_VALUE = 8'hFF;
	localparam logic [7:0] BLOCKED_BYTE = 8'h00;
	localparam logic [7:0] IDLE_TX_BYTE = 8'h00;

	// programming time per byte in crystal cycles
	localparam int HIGH_VOLTAGE_ENABLE_PIN_XTAL_CYCLES = 1600;
	localparam logic [10:0] HIGH_VOLTAGE_ENABLE_PIN_XTAL_LAST = 11'(HIGH_VOLTAGE_ENABLE_PIN_XTAL_CYCLES - 1);

	// values after reset
	localparam logic [2:0] SPI_SYNC_RESET = 3'h4;
	localparam logic RESET_UNLOCK = 1'b0;
	localparam logic RESET_PAGE = 1'b0;
	localparam logic RESET_LOCK = 1'b1;

	typedef struct packed {
		logic csn;
		logic sck;
		logic mosi;
	} sop_spi_in_s;

	typedef enum logic [3:0] {
		LK_IDLE = 4'h0,
		LK_CMD = 4'h1,
		LK_ADDR_HI = 4'h2,
		LK_ADDR_LO = 4'h3,
		LK_READ = 4'h4,
		LK_HIGH_VOLTAGE_ENABLE_PIN_IN = 4'h5,
		LK_STAT_OUT = 4'h6,
		LK_PCR_OUT = 4'h7,
		LK_STAT_WR = 4'h8,
		LK_SKIP = 4'h9
	} sop_link_state_e;

	typedef enum logic [2:0] {
		EN_BOOT = 3'h0,
		EN_BOOT_CAP = 3'h1,
		EN_IDLE = 3'h2,
		EN_FETCH = 3'h3,
		EN_WRITE = 3'h4,
		EN_WAIT = 3'h5
	} sop_eng_state_e;

	// page select plus serial address to cell index; bit 15 aliases
	function automatic logic [MEM_AW-1:0] map_addr(input logic page, input logic [15:0] a);
		logic [MEM_AW-1:0] low;
		low = a[MEM_AW-1:0];
		if (page) begin
			map_addr = PRIMARY_BYTES + {6'h00, a[8:0]};
		end else if (low >= PRIMARY_BYTES) begin
			map_addr = low - PRIMARY_BYTES;
		end else begin
			map_addr = low;
		end
	endfunction : map_addr

	// address increment that wraps after the top of the selected page
	function automatic logic [15:0] next_addr(input logic page, input logic [15:0] a);
		logic [15:0] last;
		last = page ? CONFIG_LAST_ADDR : PRIMARY_LAST_ADDR;
		next_addr = (a >= last) ? 16'h0000 : a + 16'h0001;
	endfunction : next_addr
endpackage : sop_pkg

// [design/sop_mem.sv]
`timescale 1ns/10ps
module sop_mem #(
	parameter int DEPTH = 256,
	parameter int AW = 8,
	parameter int W = 8,
	parameter bit AND_WRITE = 1'b0,
	parameter logic [W-1:0] INIT = '1
) (
	input wire logic i_clk,
	input wire logic i_rd_en,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_addr,
	input wire logic [W-1:0] i_wdata,
	output logic [W-1:0] o_rdata
);
	logic [W-1:0] cells [DEPTH];

	// cells start erased; no reset network over the array
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			cells[i] = INIT;
		end
	end

	// and-write keeps cleared bits cleared, as a fuse array would
	always_ff @(posedge i_clk) begin
		if (i_wr_en) begin
			cells[i_addr] <= AND_WRITE ? (cells[i_addr] & i_wdata) : i_wdata;
		end
		if (i_rd_en) begin
			o_rdata <= cells[i_addr];
		end
	end
endmodule : sop_mem

// [design/sop_fifo.sv]
`timescale 1ns/10ps
module sop_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_flush,
	input wire logic i_in_valid,
	input wire logic [W-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [W-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

	logic [W-1:0] slots [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	assign o_in_ready = (cnt_reg != FULL_COUNT);
	assign o_out_valid = (cnt_reg != '0);
	assign o_out_data = slots[rd_reg];
	assign push = i_in_valid & o_in_ready & ~i_flush;
	assign pop = o_out_valid & i_out_ready & ~i_flush;

	// pointers wrap naturally, so depth must be a power of two
	always_comb begin
		wr_next = wr_reg;
		rd_next = rd_reg;
		cnt_next = cnt_reg;
		if (i_flush) begin
			wr_next = '0;
			rd_next = '0;
			cnt_next = '0;
		end else begin
			if (push) begin
				wr_next = wr_reg + 1'b1;
			end
			if (pop) begin
				rd_next = rd_reg + 1'b1;
			end
			if (push & ~pop) begin
				cnt_next = cnt_reg + 1'b1;
			end else if (pop & ~push) begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// data slots carry no reset
	always_ff @(posedge i_clk) begin
		if (push) begin
			slots[wr_reg] <= i_in_data;
		end
	end
endmodule : sop_fifo

// [design/sop_top.sv]
`timescale 1ns/10ps
// What this block does
// - each transaction starts with one 8-bit command byte, then its address and data bytes
// - every byte moves most significant bit first, both directions
// - high voltage enable turns the pins into the serial slave port
// - page select 0 targets the primary array, 1 the config page
// - 0x06 sets write unlock, 0x04 clears it, single byte each
// - write unlock clears at reset and after every completed program or readout lock command
// - 0x05 returns status, repeated every byte while select stays low
// - 0x01 loads unlock bit 5 and page bit 3 of the status register from the next data byte
// - 0x03 plus 2-byte address streams bytes with address increment
// - read address wraps to zero after the page's top address
// - primary array reads return real data only while readout lock is clear
// - 0x02 plus address takes up to 256 bytes, any start offset
// - programming starts at select release, 1600 crystal cycles per byte
// - while programming only the status read command is honoured
// - cells erase to 0xFF and programming can only clear bits
// - readout lock set suppresses programming of the primary array
// - 0x85 sets readout lock and writes 0x00 to config byte 0x23
// - lock programming starts at select release and lasts 1600 crystal cycles
// - 0x89 returns the protect configuration register
// - status holds unlock bit 5, busy bit 4, page bit 3, lock bit 2
// - at start readout lock is 0 if config byte 0x23 is 0xFF, else 1
// - protect configuration register is read-only and reads 0xFF
module sop_top (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_high_voltage_enable_pin,
	input wire logic i_crystal_clock_in,
	input wire sop_pkg::sop_spi_in_s i_spi,
	output logic o_miso,
	output logic o_miso_oe,
	output logic o_slave_mode,
	output logic o_busy
);
	import sop_pkg::*;

	sop_spi_in_s spi_m_reg, spi_s_reg;
	logic sck_d_reg, hv_m_reg, hv_s_reg, xt_m_reg, xt_s_reg, xt_d_reg;
	logic active, sck_rise, sck_fall, xt_rise, cs_rise, byte_done;
	logic [7:0] rx_byte, tx_src, status;

	// two flops on every pin; edge detectors compare the second stage with a third flop
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			spi_m_reg <= SPI_SYNC_RESET;
			spi_s_reg <= SPI_SYNC_RESET;
			sck_d_reg <= 1'b0;
			hv_m_reg <= 1'b0;
			hv_s_reg <= 1'b0;
			xt_m_reg <= 1'b0;
			xt_s_reg <= 1'b0;
			xt_d_reg <= 1'b0;
		end else begin
			spi_m_reg <= i_spi;
			spi_s_reg <= spi_m_reg;
			sck_d_reg <= spi_s_reg.sck;
			hv_m_reg <= i_high_voltage_enable_pin;
			hv_s_reg <= hv_m_reg;
			xt_m_reg <= i_crystal_clock_in;
			xt_s_reg <= xt_m_reg;
			xt_d_reg <= xt_s_reg;
		end
	end

	sop_link_state_e lk_state_reg, lk_state_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [6:0] rx_reg, rx_next;
	logic [7:0] tx_reg, tx_next;
	logic miso_reg, miso_next, oe_reg, oe_next, lock_req_reg, lock_req_next;
	logic is_read_reg, is_read_next, inflight_reg, inflight_next;
	logic [15:0] addr_reg, addr_next, pf_addr_reg, pf_addr_next;
	logic [8:0] stage_cnt_reg, stage_cnt_next;
	logic set_unlock, clr_unlock, stat_wr, launch_high_voltage_enable_pin, launch_lock;
	logic stage_we, pf_rd, fifo_pop, fifo_in_ready, fifo_out_valid, fifo_in_valid;
	logic [7:0] fifo_out_data, fifo_in_data, mem_rdata, stage_rdata;

	sop_eng_state_e eng_state_reg, eng_state_next;
	logic unlock_reg, unlock_next, page_reg, page_next, lock_reg, lock_next;
	logic busy_reg, busy_next, eng_is_lock_reg, eng_is_lock_next;
	logic [8:0] eng_idx_reg, eng_idx_next, eng_n_reg, eng_n_next;
	logic [15:0] eng_addr_reg, eng_addr_next;
	logic [10:0] xt_cnt_reg, xt_cnt_next;
	logic eng_rd, eng_wr, stage_rd;
	logic [MEM_AW-1:0] eng_maddr, mem_addr;
	logic [7:0] eng_wdata;

	assign active = hv_s_reg & ~spi_s_reg.csn;
	assign sck_rise = active & spi_s_reg.sck & ~sck_d_reg;
	assign sck_fall = active & ~spi_s_reg.sck & sck_d_reg;
	assign xt_rise = xt_s_reg & ~xt_d_reg;
	assign cs_rise = oe_reg & ~active;
	assign rx_byte = {rx_reg, spi_s_reg.mosi};
	assign byte_done = sck_rise & (bit_cnt_reg == 3'h7);
	assign fifo_in_valid = inflight_reg & (lk_state_reg == LK_READ);
	assign fifo_in_data = (lock_reg & ~page_reg) ? BLOCKED_BYTE : mem_rdata;

	// status byte as shifted out; unused bits read zero
	always_comb begin
		status = 8'h00;
		status[ST_UNLOCK_BIT] = unlock_reg;
		status[ST_BUSY_BIT] = busy_reg;
		status[ST_PAGE_BIT] = page_reg;
		status[ST_LOCK_BIT] = lock_reg;
	end

	// byte to shift out next, picked by what the command wants
	always_comb begin
		case (lk_state_reg)
			LK_STAT_OUT: tx_src = status;
			LK_PCR_OUT: tx_src = PROTECT_CONFIG_VALUE;
			LK_READ: tx_src = fifo_out_valid ? fifo_out_data : ERASED_BYTE;
			default: tx_src = IDLE_TX_BYTE;
		endcase
	end

	// serial link: bit shifting, command decode, read prefetch
	always_comb begin
		lk_state_next = lk_state_reg;
		bit_cnt_next = bit_cnt_reg;
		rx_next = rx_reg;
		tx_next = tx_reg;
		miso_next = miso_reg;
		oe_next = active;
		lock_req_next = lock_req_reg;
		is_read_next = is_read_reg;
		addr_next = addr_reg;
		pf_addr_next = pf_addr_reg;
		stage_cnt_next = stage_cnt_reg;
		set_unlock = 1'b0;
		clr_unlock = 1'b0;
		stat_wr = 1'b0;
		launch_high_voltage_enable_pin = 1'b0;
		launch_lock = 1'b0;
		stage_we = 1'b0;
		pf_rd = 1'b0;
		fifo_pop = 1'b0;
		if (sck_rise) begin
			rx_next = rx_byte[6:0];
			bit_cnt_next = bit_cnt_reg + 3'h1;
		end
		// a new byte is loaded on the first falling edge after a boundary
		if (sck_fall) begin
			if (bit_cnt_reg == 3'h0) begin
				tx_next = {tx_src[6:0], 1'b0};
				miso_next = tx_src[7];
				fifo_pop = (lk_state_reg == LK_READ) & fifo_out_valid;
			end else begin
				miso_next = tx_reg[7];
				tx_next = {tx_reg[6:0], 1'b0};
			end
		end
		if (lk_state_reg == LK_IDLE) begin
			lk_state_next = LK_CMD;
		end
		if (byte_done) begin
			case (lk_state_reg)
				LK_CMD: begin
					lk_state_next = LK_SKIP;
					if (busy_reg && rx_byte != CMD_STATUS_READ) begin
						lk_state_next = LK_SKIP;
					end else begin
						case (rx_byte)
							CMD_WRITE_UNLOCK: set_unlock = 1'b1;
							CMD_WRITE_LOCK: clr_unlock = 1'b1;
							CMD_STATUS_READ: lk_state_next = LK_STAT_OUT;
							CMD_STATUS_WRITE: lk_state_next = LK_STAT_WR;
							CMD_PROTECT_CONFIG_READ: lk_state_next = LK_PCR_OUT;
							CMD_READOUT_LOCK: lock_req_next = 1'b1;
							CMD_READ: begin
								lk_state_next = LK_ADDR_HI;
								is_read_next = 1'b1;
							end
							CMD_PROGRAM: begin
								lk_state_next = LK_ADDR_HI;
								is_read_next = 1'b0;
								stage_cnt_next = 9'h000;
							end
							default: lk_state_next = LK_SKIP;
						endcase
					end
				end
				LK_ADDR_HI: begin
					addr_next[15:8] = rx_byte;
					lk_state_next = LK_ADDR_LO;
				end
				LK_ADDR_LO: begin
					addr_next[7:0] = rx_byte;
					pf_addr_next = {addr_reg[15:8], rx_byte};
					lk_state_next = is_read_reg ? LK_READ : LK_HIGH_VOLTAGE_ENABLE_PIN_IN;
				end
				LK_HIGH_VOLTAGE_ENABLE_PIN_IN: begin
					// bytes past the buffer size are dropped
					if (stage_cnt_reg != 9'(STAGE_DEPTH)) begin
						stage_we = 1'b1;
						stage_cnt_next = stage_cnt_reg + 9'h001;
					end
				end
				LK_STAT_WR: begin
					stat_wr = 1'b1;
					lk_state_next = LK_SKIP;
				end
				default: begin
				end
			endcase
		end
		// one read in flight at a time keeps the fifo from overrunning
		if (lk_state_reg == LK_READ && !inflight_reg && fifo_in_ready) begin
			pf_rd = 1'b1;
			pf_addr_next = next_addr(page_reg, pf_addr_reg);
		end
		inflight_next = pf_rd;
		if (cs_rise) begin
			launch_high_voltage_enable_pin = (lk_state_reg == LK_HIGH_VOLTAGE_ENABLE_PIN_IN) && (stage_cnt_reg != 9'h000);
			launch_lock = lock_req_reg;
		end
		if (!active) begin
			lk_state_next = LK_IDLE;
			bit_cnt_next = 3'h0;
			miso_next = 1'b0;
			tx_next = 8'h00;
			lock_req_next = 1'b0;
			inflight_next = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lk_state_reg <= LK_IDLE;
			bit_cnt_reg <= 3'h0;
			rx_reg <= 7'h00;
			tx_reg <= 8'h00;
			miso_reg <= 1'b0;
			oe_reg <= 1'b0;
			lock_req_reg <= 1'b0;
			is_read_reg <= 1'b0;
			addr_reg <= 16'h0000;
			pf_addr_reg <= 16'h0000;
			stage_cnt_reg <= 9'h000;
			inflight_reg <= 1'b0;
		end else begin
			lk_state_reg <= lk_state_next;
			bit_cnt_reg <= bit_cnt_next;
			rx_reg <= rx_next;
			tx_reg <= tx_next;
			miso_reg <= miso_next;
			oe_reg <= oe_next;
			lock_req_reg <= lock_req_next;
			is_read_reg <= is_read_next;
			addr_reg <= addr_next;
			pf_addr_reg <= pf_addr_next;
			stage_cnt_reg <= stage_cnt_next;
			inflight_reg <= inflight_next;
		end
	end

	// status bits and the self-timed programming engine
	always_comb begin
		eng_state_next = eng_state_reg;
		unlock_next = unlock_reg;
		page_next = page_reg;
		lock_next = lock_reg;
		eng_is_lock_next = eng_is_lock_reg;
		eng_idx_next = eng_idx_reg;
		eng_n_next = eng_n_reg;
		eng_addr_next = eng_addr_reg;
		xt_cnt_next = xt_cnt_reg;
		eng_rd = 1'b0;
		eng_wr = 1'b0;
		stage_rd = 1'b0;
		eng_maddr = map_addr(1'b1, LOCK_BYTE_ADDR);
		eng_wdata = LOCK_MARK;
		case (eng_state_reg)
			EN_BOOT: begin
				eng_rd = 1'b1;
				eng_state_next = EN_BOOT_CAP;
			end
			EN_BOOT_CAP: begin
				lock_next = (mem_rdata != ERASED_BYTE);
				eng_state_next = EN_IDLE;
			end
			EN_IDLE: begin
				if (set_unlock) begin
					unlock_next = 1'b1;
				end
				if (clr_unlock) begin
					unlock_next = 1'b0;
				end
				if (stat_wr) begin
					unlock_next = rx_byte[ST_UNLOCK_BIT];
					page_next = rx_byte[ST_PAGE_BIT];
				end
				// write commands without a prior unlock are dropped
				if (launch_high_voltage_enable_pin && unlock_reg) begin
					if (lock_reg && !page_reg) begin
						unlock_next = 1'b0;
					end else begin
						eng_state_next = EN_FETCH;
						eng_is_lock_next = 1'b0;
						eng_idx_next = 9'h000;
						eng_n_next = stage_cnt_reg;
						eng_addr_next = addr_reg;
					end
				end else if (launch_lock && unlock_reg) begin
					eng_state_next = EN_WRITE;
					eng_is_lock_next = 1'b1;
					eng_idx_next = 9'h000;
					eng_n_next = 9'h001;
				end
			end
			EN_FETCH: begin
				stage_rd = 1'b1;
				eng_state_next = EN_WRITE;
			end
			EN_WRITE: begin
				eng_wr = 1'b1;
				if (!eng_is_lock_reg) begin
					eng_maddr = map_addr(page_reg, eng_addr_reg);
					eng_wdata = stage_rdata;
				end
				xt_cnt_next = 11'h000;
				eng_state_next = EN_WAIT;
			end
			EN_WAIT: begin
				if (xt_rise) begin
					xt_cnt_next = xt_cnt_reg + 11'h001;
					if (xt_cnt_reg == HIGH_VOLTAGE_ENABLE_PIN_XTAL_LAST) begin
						eng_idx_next = eng_idx_reg + 9'h001;
						eng_addr_next = next_addr(page_reg, eng_addr_reg);
						eng_state_next = EN_FETCH;
						if (eng_idx_reg + 9'h001 == eng_n_reg) begin
							eng_state_next = EN_IDLE;
							unlock_next = 1'b0;
							if (eng_is_lock_reg) begin
								lock_next = 1'b1;
							end
						end
					end
				end
			end
			default: eng_state_next = EN_IDLE;
		endcase
		busy_next = (eng_state_next != EN_IDLE);
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			eng_state_reg <= EN_BOOT;
			unlock_reg <= RESET_UNLOCK;
			page_reg <= RESET_PAGE;
			lock_reg <= RESET_LOCK;
			busy_reg <= 1'b1;
			eng_is_lock_reg <= 1'b0;
			eng_idx_reg <= 9'h000;
			eng_n_reg <= 9'h000;
			eng_addr_reg <= 16'h0000;
			xt_cnt_reg <= 11'h000;
		end else begin
			eng_state_reg <= eng_state_next;
			unlock_reg <= unlock_next;
			page_reg <= page_next;
			lock_reg <= lock_next;
			busy_reg <= busy_next;
			eng_is_lock_reg <= eng_is_lock_next;
			eng_idx_reg <= eng_idx_next;
			eng_n_reg <= eng_n_next;
			eng_addr_reg <= eng_addr_next;
			xt_cnt_reg <= xt_cnt_next;
		end
	end

	// prefetch owns the array only while the engine is idle
	assign mem_addr = (eng_state_reg == EN_IDLE) ? map_addr(page_reg, pf_addr_reg) : eng_maddr;

	sop_mem #(.DEPTH(MEM_DEPTH), .AW(MEM_AW), .W(8), .AND_WRITE(1'b1), .INIT(ERASED_BYTE))
	u_array (
		.i_clk(i_sys_clk),
		.i_rd_en(pf_rd | eng_rd),
		.i_wr_en(eng_wr),
		.i_addr(mem_addr),
		.i_wdata(eng_wdata),
		.o_rdata(mem_rdata)
	);

	sop_mem #(.DEPTH(STAGE_DEPTH), .AW(STAGE_AW), .W(8), .AND_WRITE(1'b0), .INIT(ERASED_BYTE))
	u_stage (
		.i_clk(i_sys_clk),
		.i_rd_en(stage_rd),
		.i_wr_en(stage_we),
		.i_addr(stage_we ? stage_cnt_reg[7:0] : eng_idx_reg[7:0]),
		.i_wdata(rx_byte),
		.o_rdata(stage_rdata)
	);

	sop_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_read_fifo (
		.i_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_flush(lk_state_reg != LK_READ),
		.i_in_valid(fifo_in_valid),
		.i_in_data(fifo_in_data),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out_data),
		.i_out_ready(fifo_pop)
	);

	assign o_miso = miso_reg;
	assign o_miso_oe = oe_reg;
	assign o_slave_mode = hv_s_reg;
	assign o_busy = busy_reg;
endmodule : sop_top

// [dv/sop_top_assertions.sv]
`timescale 1ns/10ps
module sop_top_assertions (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_high_voltage_enable_pin,
	input wire logic i_crystal_clock_in,
	input wire sop_pkg::sop_spi_in_s i_spi,
	input wire logic o_miso,
	input wire logic o_miso_oe,
	input wire logic o_slave_mode,
	input wire logic o_busy
);
	import sop_pkg::*;
	logic xtal_reg;
	logic busy_reg;
	logic armed_reg;
	logic armed_next;
	logic [19:0] xcnt_reg;
	logic [19:0] xcnt_next;
	// crystal rises since busy rose; boot busy is never armed
	always_comb begin
		armed_next = armed_reg;
		xcnt_next = xcnt_reg;
		if (o_busy && !busy_reg) begin
			armed_next = 1'b1;
			xcnt_next = 20'h00000;
		end else if (o_busy && i_crystal_clock_in && !xtal_reg) begin
			xcnt_next = xcnt_reg + 20'h00001;
		end
	end
	// busy resets high so the boot phase never looks like a rise
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			xtal_reg <= 1'b0;
			busy_reg <= 1'b1;
			armed_reg <= 1'b0;
			xcnt_reg <= 20'h00000;
		end else begin
			xtal_reg <= i_crystal_clock_in;
			busy_reg <= o_busy;
			armed_reg <= armed_next;
			xcnt_reg <= xcnt_next;
		end
	end
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	AST_OE_IDLE: assert property (i_spi.csn [*6] |-> !o_miso_oe && !o_miso)
		else $error("miso active while deselected");
	AST_HV_OFF: assert property (!i_high_voltage_enable_pin [*6] |-> !o_slave_mode && !o_miso_oe)
		else $error("port active without hv enable");
	AST_HV_ON: assert property (i_high_voltage_enable_pin [*6] |-> o_slave_mode)
		else $error("slave mode missing");
	AST_OE_ON: assert property ((!i_spi.csn && i_high_voltage_enable_pin) [*6] |-> o_miso_oe)
		else $error("miso not driven while selected");
	AST_MISO_HOLD: assert property ((!i_spi.csn && i_spi.sck) [*6] |-> $stable(o_miso))
		else $error("miso moved while clock high");
	AST_BUSY_DESEL: assert property ($rose(o_busy) |-> $past(i_spi.csn, 1) && $past(i_spi.csn, 2))
		else $error("programming began while selected");
	AST_HIGH_VOLTAGE_ENABLE_PIN_MIN: assert property (armed_reg && $fell(o_busy) |-> xcnt_reg >= 20'h0063F)
		else $error("programming too short");
	AST_HIGH_VOLTAGE_ENABLE_PIN_MAX: assert property (armed_reg && o_busy |-> xcnt_reg <= 20'h64004)
		else $error("programming too long");
	cover property (armed_reg && $fell(o_busy));
	cover property ($rose(o_miso_oe));
	cover property (o_miso && !i_spi.csn);
endmodule : sop_top_assertions
bind sop_top sop_top_assertions sop_top_assertions_i (
	.i_sys_clk(i_sys_clk),
	.i_resetn(i_resetn),
	.i_high_voltage_enable_pin(i_high_voltage_enable_pin),
	.i_crystal_clock_in(i_crystal_clock_in),
	.i_spi(i_spi),
	.o_miso(o_miso),
	.o_miso_oe(o_miso_oe),
	.o_slave_mode(o_slave_mode),
	.o_busy(o_busy)
);

// [dv/sop_high_voltage_enable_pin_model.sv]
`timescale 1ns/10ps
module sop_high_voltage_enable_pin_model #(
	parameter int HV_WAIT = 200,
	parameter int HALF = 6
) (
	input wire logic i_sys_clk,
	input wire logic i_miso,
	output sop_pkg::sop_spi_in_s o_spi,
	output logic o_hv_en
);
	import sop_pkg::*;
	// deselected, serial clock parked low
	initial begin
		o_spi = '{csn: 1'b1, sck: 1'b0, mosi: 1'b0};
		o_hv_en = 1'b0;
	end
	// settle shortened to keep the run brief
	task automatic port_on();
		o_hv_en <= 1'b1;
		repeat (HV_WAIT) @(posedge i_sys_clk);
	endtask : port_on
	task automatic sel();
		@(posedge i_sys_clk);
		o_spi.csn <= 1'b0;
		repeat (HALF) @(posedge i_sys_clk);
	endtask : sel
	// released mosi flips so a stale level never looks valid
	task automatic desel();
		o_spi.sck <= 1'b0;
		repeat (HALF) @(posedge i_sys_clk);
		o_spi.csn <= 1'b1;
		o_spi.mosi <= ~o_spi.mosi;
		repeat (8) @(posedge i_sys_clk);
	endtask : desel
	// mode 0: mosi set with the fall, miso taken at the rise
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_spi.sck <= 1'b0;
			o_spi.mosi <= tx[i];
			repeat (HALF) @(posedge i_sys_clk);
			o_spi.sck <= 1'b1;
			rx[i] = i_miso;
			repeat (HALF) @(posedge i_sys_clk);
		end
	endtask : xfer
endmodule : sop_high_voltage_enable_pin_model

// [dv/sop_top_tb.sv]
`timescale 1ns/10ps
module sop_top_tb;
	import sop_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] xdiv = 2'h0;
	sop_spi_in_s spi;
	logic hv;
	logic miso;
	int miscompares = 0;
	int n_compared = 0;
	// crystal at a quarter rate keeps each program byte short
	always #5 clk = ~clk;
	always @(posedge clk) xdiv <= xdiv + 2'h1;
	sop_top sop_top_i (.i_sys_clk(clk), .i_resetn(resetn), .i_high_voltage_enable_pin(hv),
		.i_crystal_clock_in(xdiv[1]), .i_spi(spi), .o_miso(miso), .o_miso_oe(),
		.o_slave_mode(), .o_busy());
	sop_high_voltage_enable_pin_model sop_high_voltage_enable_pin_model_i (.i_sys_clk(clk), .i_miso(miso), .o_spi(spi), .o_hv_en(hv));
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [7:0] stb(input logic u, input logic p, input logic l);
		stb = 8'h00;
		stb[ST_UNLOCK_BIT] = u;
		stb[ST_PAGE_BIT] = p;
		stb[ST_LOCK_BIT] = l;
	endfunction : stb
	task automatic do_reset();
		resetn <= 1'b0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		sop_high_voltage_enable_pin_model_i.port_on();
	endtask : do_reset
	// one transaction: bytes out, a pause, then up to two reply bytes
	task automatic txn(input logic [7:0] b[$], input int nrd, input int gap,
		output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] rx;
		sop_high_voltage_enable_pin_model_i.sel();
		foreach (b[i]) sop_high_voltage_enable_pin_model_i.xfer(b[i], rx);
		repeat (gap) @(posedge clk);
		if (nrd > 0) sop_high_voltage_enable_pin_model_i.xfer(8'h00, r0);
		if (nrd > 1) sop_high_voltage_enable_pin_model_i.xfer(8'h00, r1);
		sop_high_voltage_enable_pin_model_i.desel();
	endtask : txn
	task automatic put(input logic [7:0] b[$]);
		logic [7:0] r0;
		logic [7:0] r1;
		txn(b, 0, 0, r0, r1);
	endtask : put
	task automatic expect2(input logic [7:0] b[$], input int gap, input logic [7:0] e0,
		input logic [7:0] e1);
		logic [7:0] r0;
		logic [7:0] r1;
		txn(b, 2, gap, r0, r1);
		chk(r0, e0);
		chk(r1, e1);
	endtask : expect2
	task automatic stat(input logic [7:0] e);
		expect2('{CMD_STATUS_READ}, 0, e, e);
	endtask : stat
	task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
		expect2('{CMD_READ, a[15:8], a[7:0]}, 40, e0, e1);
	endtask : rd
	// polls status; a hang is cut short after a fixed count
	task automatic wait_idle(input logic busy_exp);
		logic [7:0] r0;
		logic [7:0] r1;
		int k;
		for (k = 0; k < 300; k++) begin
			txn('{CMD_STATUS_READ}, 1, 0, r0, r1);
			if (k == 0 && busy_exp) chk({7'h00, r0[ST_BUSY_BIT]}, 8'h01);
			if (r0[ST_BUSY_BIT] === 1'b0) break;
		end
		if (k == 300) begin
			miscompares++;
			$display("mismatch at %0t: still busy", $time);
			tally_and_finish();
		end
	endtask : wait_idle
	initial begin
		do_reset();
		stat(stb(0, 0, 0));
		expect2('{CMD_PROTECT_CONFIG_READ}, 0, 8'hFF, 8'hFF);
		put('{CMD_WRITE_UNLOCK});
		stat(stb(1, 0, 0));
		put('{CMD_WRITE_LOCK});
		put('{8'h52});
		put('{8'h84});
		stat(stb(0, 0, 0));
		$display("test commands done");
		put('{CMD_WRITE_UNLOCK});
		put('{CMD_PROGRAM, 8'h43, 8'hFF, 8'hA5, 8'h3C});
		put('{CMD_STATUS_WRITE, 8'h08});
		wait_idle(1'b1);
		stat(stb(0, 0, 0));
		rd(16'h43FF, 8'hA5, 8'h3C);
		put('{CMD_PROGRAM, 8'h00, 8'h00, 8'h00});
		wait_idle(1'b0);
		rd(16'h0000, 8'h3C, 8'hFF);
		put('{CMD_WRITE_UNLOCK});
		put('{CMD_PROGRAM, 8'h00, 8'h00, 8'hF0});
		wait_idle(1'b1);
		rd(16'h0000, 8'h30, 8'hFF);
		$display("test program done");
		put('{CMD_STATUS_WRITE, 8'h08});
		stat(stb(0, 1, 0));
		rd(16'h0000, 8'hFF, 8'hFF);
		put('{CMD_WRITE_UNLOCK});
		put('{CMD_READOUT_LOCK});
		wait_idle(1'b1);
		stat(stb(0, 1, 1));
		rd(16'h0022, 8'hFF, 8'h00);
		put('{CMD_STATUS_WRITE, 8'h00});
		rd(16'h43FF, 8'h00, 8'h00);
		// a locked primary program must not start: busy stays low, unlock drops
		put('{CMD_WRITE_UNLOCK});
		put('{CMD_PROGRAM, 8'h00, 8'h01, 8'h00});
		stat(stb(0, 0, 1));
		$display("test lock done");
		do_reset();
		stat(stb(0, 0, 1));
		$display("test restart done");
		tally_and_finish();
	end
endmodule : sop_top_tb
